// file: design/cos_out_mux.sv
// one contact output: picks the condition by signal type and applies polarity.
// assumes conditions are already synchronous to ref_clk; output is registered.
`timescale 1ns/100ps
module cos_out_mux (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire cos_pkg::cos_cfg_t cfg,
  input  wire cos_pkg::cos_cond_t cond,
  input  wire logic              sel_alarm,
  output logic                   contact
);
  logic asserted;
  logic next_contact;

  always_comb
  begin
    asserted = 1'b0;
    unique case (cfg.sel)
      cos_pkg::COS_SIG_OFF:  asserted = 1'b0;
      cos_pkg::COS_SIG_RUN:  asserted = cond.running;
      cos_pkg::COS_SIG_RMT:  asserted = cond.remote;
      cos_pkg::COS_SIG_STOP: asserted = cond.stop_alarm;
      cos_pkg::COS_SIG_WARN: asserted = cond.warn_alarm;
      cos_pkg::COS_SIG_ANY:  asserted = cond.stop_alarm | cond.warn_alarm;
      cos_pkg::COS_SIG_RDY:  asserted = cond.temp_ready;
      cos_pkg::COS_SIG_FREZ: asserted = cond.freeze_on;
      cos_pkg::COS_SIG_IN1:  asserted = cond.in1;
      cos_pkg::COS_SIG_IN2:  asserted = cond.in2;
      cos_pkg::COS_SIG_ASEL: asserted = sel_alarm;
      default:               asserted = 1'b0;
    endcase
    if (cfg.sel == cos_pkg::COS_SIG_OFF)
      next_contact = 1'b0;
    else
      next_contact = asserted ^ cfg.nc;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      contact <= 1'b0;
    else
      contact <= next_contact;
  end
endmodule // cos_out_mux

// file: design/cos_pkg.sv
// package for the contact output selector: signal-type codes, alarm numbers,
// register map and field layouts.
// assumes one 10 MHz system clock and a synchronous active-high reset.
package cos_pkg;

  localparam int NUM_OUT   = 3;
  localparam int ALARM_W   = 7;
  localparam int NUM_ALARM = 128;
  localparam int SIG_W     = 4;

  // signal-type codes
  typedef enum logic [3:0] {
    COS_SIG_OFF  = 4'h0,
    COS_SIG_RUN  = 4'h1,
    COS_SIG_RMT  = 4'h2,
    COS_SIG_STOP = 4'h3,
    COS_SIG_WARN = 4'h4,
    COS_SIG_ANY  = 4'h5,
    COS_SIG_RDY  = 4'h6,
    COS_SIG_FREZ = 4'h7,
    COS_SIG_IN1  = 4'h8,
    COS_SIG_IN2  = 4'h9,
    COS_SIG_ASEL = 4'ha
  } cos_sig_t;

  // selected alarm numbers that the chosen-alarm output must match
  localparam logic [6:0] ALARM_INPUT1 = 7'h1f;
  localparam logic [6:0] ALARM_INPUT2 = 7'h20;
  localparam logic [6:0] ALARM_COND   = 7'h24;

  // per-output configuration
  typedef struct packed {
    cos_sig_t             sel;
    logic                 nc;
    logic [ALARM_W-1:0]   alarm_no;
  } cos_cfg_t;

  // internal conditions shared by all outputs
  typedef struct packed {
    logic running;
    logic remote;
    logic stop_alarm;
    logic warn_alarm;
    logic temp_ready;
    logic freeze_on;
    logic in1;
    logic in2;
  } cos_cond_t;

  // register map, byte addresses
  localparam logic [7:0] ADDR_CFG0   = 8'h00;
  localparam logic [7:0] ADDR_CFG1   = 8'h04;
  localparam logic [7:0] ADDR_CFG2   = 8'h08;
  localparam logic [7:0] ADDR_STATE  = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_MASK   = 8'h14;

  // cfg register fields: [6:0] alarm number, [8] nc, [15:12] signal type
  localparam int CFG_ALARM_LSB = 0;
  localparam int CFG_NC_BIT    = 8;
  localparam int CFG_SEL_LSB   = 12;

  // reset configuration: out1 run/no, out2 any alarm/nc, out3 ready/no
  localparam cos_cfg_t CFG0_RST = '{sel: COS_SIG_RUN, nc: 1'b0, alarm_no: 7'h01};
  localparam cos_cfg_t CFG1_RST = '{sel: COS_SIG_ANY, nc: 1'b1, alarm_no: 7'h01};
  localparam cos_cfg_t CFG2_RST = '{sel: COS_SIG_RDY, nc: 1'b0, alarm_no: 7'h01};

  localparam logic [2:0] MASK_RST = 3'h0;

endpackage

// file: design/cos_sync.sv
// two-flop synchroniser for one level from outside the clock domain.
// assumes the input is a slow level such as a contact input.
`timescale 1ns/100ps
module cos_sync (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic din,
  output logic      dout
);
  logic meta;
  logic next_meta;
  logic next_dout;

  always_comb
  begin
    next_meta = din;
    next_dout = meta;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      meta <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      meta <= next_meta;
      dout <= next_dout;
    end
  end
endmodule // cos_sync

// file: design/cos_top.sv
// contact output selector: three configurable relay contact outputs with
// register port, interrupt on contact changes.
// assumes alarm vector and status inputs come from same-clock logic; the two
// contact inputs come from pins and are synchronised here.
//
// Summary of operation
// - three independent outputs, each with its own type, polarity and alarm number, held as levels.
// - the signal type picks the condition and the polarity decides close or open when asserted.
// - fault-stop type closes (no) or opens (nc) while a stop-class alarm is active.
// - warning type closes (no) or opens (nc) while a warning-class alarm is active.
// - general alarm type is asserted while any alarm of either class is active.
// - temperature-ready type follows the ready status with the chosen polarity.
// - pass-through with no polarity copies the chosen contact input as it is.
// - pass-through with nc polarity drives the inverse of the chosen contact input.
// - chosen-alarm type is asserted only while the configured alarm number is active.
// - alarm number for contact input 1 detection can be chosen and matched.
// - a distinct alarm number for contact input 2 detection can be chosen and matched.
// - conductivity-sensor failure number is matched like every other number.
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
module cos_top (
  input  wire logic                           ref_clk,
  input  wire logic                           rst,
  input  wire logic [7:0]                     addr,
  input  wire logic [31:0]                    wdata,
  input  wire logic                           wr,
  input  wire logic                           rd,
  output logic [31:0]                         rdata,
  input  wire logic                           running,
  input  wire logic                           remote,
  input  wire logic                           temp_ready,
  input  wire logic                           freeze_on,
  input  wire logic [cos_pkg::NUM_ALARM-1:0]  alarm_active,
  input  wire logic [cos_pkg::NUM_ALARM-1:0]  alarm_is_stop,
  input  wire logic                           contact_in1,
  input  wire logic                           contact_in2,
  output logic [cos_pkg::NUM_OUT-1:0]         contact_out,
  output logic                                irq
);
  localparam int N = cos_pkg::NUM_OUT;

  // the state word packs exactly three contacts; alarm numbers must index the whole vector
  if (N != 3 || cos_pkg::NUM_ALARM != (1 << cos_pkg::ALARM_W))
  begin : g_bad_size
    $error("output count or alarm width not supported");
  end

  cos_pkg::cos_cfg_t cfg [N];
  cos_pkg::cos_cfg_t next_cfg [N];
  logic [N-1:0]      status;
  logic [N-1:0]      next_status;
  logic [N-1:0]      mask;
  logic [N-1:0]      next_mask;
  logic [31:0]       next_rdata;
  logic              next_irq;
  logic              in1_s;
  logic              in2_s;
  logic              stop_any;
  logic              warn_any;
  logic [N-1:0]      sel_alarm;
  logic [N-1:0]      contact;
  logic [N-1:0]      contact_d;
  cos_pkg::cos_cond_t cond;

  function automatic cos_pkg::cos_cfg_t cfg_from_word(input logic [31:0] w);
    cos_pkg::cos_cfg_t c;
    c.sel      = cos_pkg::cos_sig_t'(w[cos_pkg::CFG_SEL_LSB +: cos_pkg::SIG_W]);
    c.nc       = w[cos_pkg::CFG_NC_BIT];
    c.alarm_no = w[cos_pkg::CFG_ALARM_LSB +: cos_pkg::ALARM_W];
    return c;
  endfunction

  function automatic logic [31:0] cfg_to_word(input cos_pkg::cos_cfg_t c);
    logic [31:0] w;
    w = 32'h0;
    w[cos_pkg::CFG_SEL_LSB +: cos_pkg::SIG_W]     = c.sel;
    w[cos_pkg::CFG_NC_BIT]                        = c.nc;
    w[cos_pkg::CFG_ALARM_LSB +: cos_pkg::ALARM_W] = c.alarm_no;
    return w;
  endfunction

  // pin inputs through two flops
  cos_sync u_sync1 (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     (contact_in1),
    .dout    (in1_s)
  );

  cos_sync u_sync2 (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     (contact_in2),
    .dout    (in2_s)
  );

  // alarm class summary
  always_comb
  begin
    stop_any = |(alarm_active & alarm_is_stop);
    warn_any = |(alarm_active & ~alarm_is_stop);
    cond.running    = running;
    cond.remote     = remote;
    cond.stop_alarm = stop_any;
    cond.warn_alarm = warn_any;
    cond.temp_ready = temp_ready;
    cond.freeze_on  = freeze_on;
    cond.in1        = in1_s;
    cond.in2        = in2_s;
  end

  for (genvar i = 0; i < N; i++)
  begin : g_out
    // sensor failure code
    // every listed number indexes the same vector, so none is special
    assign sel_alarm[i] = alarm_active[cfg[i].alarm_no];

    cos_out_mux u_mux (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .cfg       (cfg[i]),
      .cond      (cond),
      .sel_alarm (sel_alarm[i]),
      .contact   (contact[i])
    );
  end

  assign contact_out = contact;

  // register file and interrupt
  always_comb
  begin
    for (int i = 0; i < N; i++)
    begin
      next_cfg[i] = cfg[i];
    end
    next_mask   = mask;
    next_status = status;
    next_rdata  = 32'h0;
    if (wr)
    begin
      unique case (addr)
        cos_pkg::ADDR_CFG0:   next_cfg[0] = cfg_from_word(wdata);
        cos_pkg::ADDR_CFG1:   next_cfg[1] = cfg_from_word(wdata);
        cos_pkg::ADDR_CFG2:   next_cfg[2] = cfg_from_word(wdata);
        cos_pkg::ADDR_MASK:   next_mask   = wdata[N-1:0];
        cos_pkg::ADDR_STATUS: next_status = status & ~wdata[N-1:0];
        default:              next_mask   = mask;
      endcase
    end
    // a contact change sets its bit; set beats a same-cycle clear
    next_status = next_status | (contact ^ contact_d);
    if (rd)
    begin
      unique case (addr)
        cos_pkg::ADDR_CFG0:   next_rdata = cfg_to_word(cfg[0]);
        cos_pkg::ADDR_CFG1:   next_rdata = cfg_to_word(cfg[1]);
        cos_pkg::ADDR_CFG2:   next_rdata = cfg_to_word(cfg[2]);
        cos_pkg::ADDR_STATE:  next_rdata = {27'h0, in2_s, in1_s, contact};
        cos_pkg::ADDR_STATUS: next_rdata = {29'h0, status};
        cos_pkg::ADDR_MASK:   next_rdata = {29'h0, mask};
        default:              next_rdata = 32'h0;
      endcase
    end
    next_irq = |(next_status & next_mask);
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cfg[0]    <= cos_pkg::CFG0_RST;
      cfg[1]    <= cos_pkg::CFG1_RST;
      cfg[2]    <= cos_pkg::CFG2_RST;
      mask      <= cos_pkg::MASK_RST;
      status    <= '0;
      contact_d <= '0;
      rdata     <= 32'h0;
      irq       <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < N; i++)
      begin
        cfg[i] <= next_cfg[i];
      end
      mask      <= next_mask;
      status    <= next_status;
      contact_d <= contact;
      rdata     <= next_rdata;
      irq       <= next_irq;
    end
  end

  // assertions on outputs 0, 1 and 2
  // disabled output stays open
  a_disabled_open: assert property (@(posedge ref_clk) disable iff (rst)
    $past(cfg[0].sel) == cos_pkg::COS_SIG_OFF |-> !contact_out[0])
    else $error("disabled output not open");
  a_stop_contact: assert property (@(posedge ref_clk) disable iff (rst)
    cfg[0].sel == cos_pkg::COS_SIG_STOP ##1 $stable(cfg[0])
    |-> contact_out[0] == ($past(stop_any) ^ $past(cfg[0].nc)))
    else $error("stop alarm contact wrong");
  a_warn_contact: assert property (@(posedge ref_clk) disable iff (rst)
    cfg[0].sel == cos_pkg::COS_SIG_WARN ##1 $stable(cfg[0])
    |-> contact_out[0] == ($past(warn_any) ^ $past(cfg[0].nc)))
    else $error("warning contact wrong");
  a_any_contact: assert property (@(posedge ref_clk) disable iff (rst)
    cfg[1].sel == cos_pkg::COS_SIG_ANY && cfg[1].nc && |alarm_active
    |=> !contact_out[1])
    else $error("any alarm contact not open");
  a_ready_contact: assert property (@(posedge ref_clk) disable iff (rst)
    cfg[2].sel == cos_pkg::COS_SIG_RDY && !cfg[2].nc |=> contact_out[2] == $past(temp_ready))
    else $error("ready contact wrong");
  a_pass_copy: assert property (@(posedge ref_clk) disable iff (rst)
    cfg[0].sel == cos_pkg::COS_SIG_IN1 && !cfg[0].nc |=> contact_out[0] == $past(in1_s))
    else $error("pass-through copy wrong");
  a_pass_invert: assert property (@(posedge ref_clk) disable iff (rst)
    cfg[0].sel == cos_pkg::COS_SIG_IN2 && cfg[0].nc |=> contact_out[0] == !$past(in2_s))
    else $error("pass-through invert wrong");
  a_sel_alarm: assert property (@(posedge ref_clk) disable iff (rst)
    cfg[1].sel == cos_pkg::COS_SIG_ASEL && !cfg[1].nc
    && cfg[1].alarm_no == cos_pkg::ALARM_INPUT1 |=> contact_out[1] == $past(alarm_active[31]))
    else $error("chosen alarm contact wrong");
  a_run_contact: assert property (@(posedge ref_clk) disable iff (rst)
    cfg[0].sel == cos_pkg::COS_SIG_RUN |=> contact_out[0] == ($past(running) ^ $past(cfg[0].nc)))
    else $error("run contact wrong");

  a_sel_input2: assert property (@(posedge ref_clk) disable iff (rst)
    cfg[2].sel == cos_pkg::COS_SIG_ASEL && cfg[2].alarm_no == cos_pkg::ALARM_INPUT2
    |=> contact_out[2] == ($past(alarm_active[32]) ^ $past(cfg[2].nc)))
    else $error("input 2 alarm contact wrong");
  a_sel_sensor: assert property (@(posedge ref_clk) disable iff (rst)
    cfg[0].sel == cos_pkg::COS_SIG_ASEL && cfg[0].alarm_no == cos_pkg::ALARM_COND
    |=> contact_out[0] == ($past(alarm_active[36]) ^ $past(cfg[0].nc)))
    else $error("sensor failure alarm contact wrong");
  a_any_close: assert property (@(posedge ref_clk) disable iff (rst)
    cfg[2].sel == cos_pkg::COS_SIG_ANY && !cfg[2].nc && |alarm_active |=> contact_out[2])
    else $error("any alarm contact not closed");
  a_pass_in2: assert property (@(posedge ref_clk) disable iff (rst)
    cfg[1].sel == cos_pkg::COS_SIG_IN2 && !cfg[1].nc |=> contact_out[1] == $past(in2_s))
    else $error("input 2 pass-through wrong");
  a_invert_in1: assert property (@(posedge ref_clk) disable iff (rst)
    cfg[2].sel == cos_pkg::COS_SIG_IN1 && cfg[2].nc |=> contact_out[2] == !$past(in1_s))
    else $error("input 1 invert wrong");
  a_ready_nc: assert property (@(posedge ref_clk) disable iff (rst)
    cfg[2].sel == cos_pkg::COS_SIG_RDY && cfg[2].nc |=> contact_out[2] == !$past(temp_ready))
    else $error("ready nc contact wrong");

  // status, interrupt and read data
  a_irq_level: assert property (@(posedge ref_clk) disable iff (rst)
    irq == |(status & mask))
    else $error("irq does not follow status and mask");
  a_rdata_idle: assert property (@(posedge ref_clk) disable iff (rst)
    !rd |=> rdata == 32'h0)
    else $error("read data without read");

  for (genvar j = 0; j < N; j++)
  begin : g_chk
    a_off_open: assert property (@(posedge ref_clk) disable iff (rst)
      cfg[j].sel == cos_pkg::COS_SIG_OFF |=> !contact_out[j])
      else $error("disabled output closed");
    // contact change sets status
    a_change_status: assert property (@(posedge ref_clk) disable iff (rst)
      $changed(contact_out[j]) |=> status[j])
      else $error("contact change not latched");
    a_run_each: assert property (@(posedge ref_clk) disable iff (rst)
      cfg[j].sel == cos_pkg::COS_SIG_RUN
      |=> contact_out[j] == ($past(running) ^ $past(cfg[j].nc)))
      else $error("run contact wrong on output");
    a_stop_each: assert property (@(posedge ref_clk) disable iff (rst)
      cfg[j].sel == cos_pkg::COS_SIG_STOP
      |=> contact_out[j] == ($past(stop_any) ^ $past(cfg[j].nc)))
      else $error("stop contact wrong on output");
    a_warn_each: assert property (@(posedge ref_clk) disable iff (rst)
      cfg[j].sel == cos_pkg::COS_SIG_WARN
      |=> contact_out[j] == ($past(warn_any) ^ $past(cfg[j].nc)))
      else $error("warning contact wrong on output");
  end
endmodule // cos_top

// file: tb/cos_contact_reader.sv
// customer equipment reading the three dry contacts of the selector.
// assumes contacts are sampled on the controller clock, 1 = closed.
`timescale 1ns/100ps
module cos_contact_reader (
  input  wire logic       ref_clk,
  input  wire logic [2:0] contact,
  output logic [2:0]      sensed
);
  // contacts are read as levels, not pulses
  always_ff @(posedge ref_clk)
  begin
    sensed <= contact;
  end
endmodule // cos_contact_reader

// file: tb/cos_tb_top.sv
// self-checking bench for the contact output selector.
// assumes a 10 MHz clock, synchronous active-high reset and the plain register port.
`timescale 1ns/100ps
module contact_output_selector_tb_top;
  typedef struct packed {
    cos_pkg::cos_sig_t sel;
    logic              nc;
    logic [6:0]        an;
    logic              run;
    logic              rdy;
    logic              i1;
    logic              i2;
    logic [7:0]        act;
    logic              stp;
    logic              ex;
  } cos_row_t;

  logic         ref_clk = 1'b0;
  logic         rst     = 1'b1;
  logic [7:0]   addr    = 8'h00;
  logic [31:0]  wdata   = 32'h0;
  logic         wr      = 1'b0;
  logic         rd      = 1'b0;
  logic [31:0]  rdata;
  logic         running = 1'b0;
  logic         temp_ready = 1'b0;
  logic         remote     = 1'b0;
  logic         freeze_on  = 1'b0;
  logic [127:0] alarm_active = '0;
  logic [127:0] alarm_is_stop = '0;
  logic         contact_in1 = 1'b0;
  logic         contact_in2 = 1'b0;
  logic [2:0]   contact_out;
  logic [2:0]   sensed;
  logic         irq;
  int           bad_count = 0;
  int           samples_checked = 0;
  logic [31:0]  rv;
  cos_row_t     rows [20] = '{
    '{cos_pkg::COS_SIG_OFF,  1'b1, 7'h01, 1'b1, 1'b1, 1'b1, 1'b1, 8'h05, 1'b1, 1'b0},
    '{cos_pkg::COS_SIG_RUN,  1'b0, 7'h01, 1'b1, 1'b0, 1'b0, 1'b0, 8'hff, 1'b0, 1'b1},
    '{cos_pkg::COS_SIG_RUN,  1'b1, 7'h01, 1'b1, 1'b0, 1'b0, 1'b0, 8'hff, 1'b0, 1'b0},
    '{cos_pkg::COS_SIG_STOP, 1'b0, 7'h01, 1'b0, 1'b0, 1'b0, 1'b0, 8'h05, 1'b1, 1'b1},
    '{cos_pkg::COS_SIG_STOP, 1'b1, 7'h01, 1'b0, 1'b0, 1'b0, 1'b0, 8'h05, 1'b1, 1'b0},
    '{cos_pkg::COS_SIG_STOP, 1'b0, 7'h01, 1'b0, 1'b0, 1'b0, 1'b0, 8'h05, 1'b0, 1'b0},
    '{cos_pkg::COS_SIG_WARN, 1'b0, 7'h01, 1'b0, 1'b0, 1'b0, 1'b0, 8'h05, 1'b0, 1'b1},
    '{cos_pkg::COS_SIG_WARN, 1'b1, 7'h01, 1'b0, 1'b0, 1'b0, 1'b0, 8'h05, 1'b0, 1'b0},
    '{cos_pkg::COS_SIG_ANY,  1'b0, 7'h01, 1'b0, 1'b0, 1'b0, 1'b0, 8'h40, 1'b1, 1'b1},
    '{cos_pkg::COS_SIG_ANY,  1'b1, 7'h01, 1'b0, 1'b0, 1'b0, 1'b0, 8'hff, 1'b0, 1'b1},
    '{cos_pkg::COS_SIG_RDY,  1'b0, 7'h01, 1'b0, 1'b1, 1'b0, 1'b0, 8'hff, 1'b0, 1'b1},
    '{cos_pkg::COS_SIG_RDY,  1'b1, 7'h01, 1'b0, 1'b1, 1'b0, 1'b0, 8'hff, 1'b0, 1'b0},
    '{cos_pkg::COS_SIG_IN1,  1'b0, 7'h01, 1'b0, 1'b0, 1'b1, 1'b0, 8'hff, 1'b0, 1'b1},
    '{cos_pkg::COS_SIG_IN2,  1'b0, 7'h01, 1'b0, 1'b0, 1'b0, 1'b1, 8'hff, 1'b0, 1'b1},
    '{cos_pkg::COS_SIG_IN1,  1'b1, 7'h01, 1'b0, 1'b0, 1'b1, 1'b0, 8'hff, 1'b0, 1'b0},
    '{cos_pkg::COS_SIG_IN2,  1'b1, 7'h01, 1'b0, 1'b0, 1'b1, 1'b0, 8'hff, 1'b0, 1'b1},
    '{cos_pkg::COS_SIG_ASEL, 1'b0, 7'h1f, 1'b0, 1'b0, 1'b0, 1'b0, 8'h1f, 1'b0, 1'b1},
    '{cos_pkg::COS_SIG_ASEL, 1'b0, 7'h20, 1'b0, 1'b0, 1'b0, 1'b0, 8'h1f, 1'b0, 1'b0},
    '{cos_pkg::COS_SIG_ASEL, 1'b1, 7'h24, 1'b0, 1'b0, 1'b0, 1'b0, 8'h24, 1'b0, 1'b0},
    '{cos_pkg::COS_SIG_ASEL, 1'b0, 7'h24, 1'b0, 1'b0, 1'b0, 1'b0, 8'h24, 1'b1, 1'b1}};

  always #50 ref_clk = ~ref_clk;

  cos_top u_dut (
    .ref_clk       (ref_clk),
    .rst           (rst),
    .addr          (addr),
    .wdata         (wdata),
    .wr            (wr),
    .rd            (rd),
    .rdata         (rdata),
    .running       (running),
    .remote        (remote),
    .temp_ready    (temp_ready),
    .freeze_on     (freeze_on),
    .alarm_active  (alarm_active),
    .alarm_is_stop (alarm_is_stop),
    .contact_in1   (contact_in1),
    .contact_in2   (contact_in2),
    .contact_out   (contact_out),
    .irq           (irq)
  );

  cos_contact_reader u_reader (
    .ref_clk (ref_clk),
    .contact (contact_out),
    .sensed  (sensed)
  );

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask

  function automatic logic [31:0] cfg_word(input cos_row_t r);
    return {16'h0, r.sel, 3'h0, r.nc, 1'b0, r.an};
  endfunction

  // one alarm bit from a row; 8'hff means no alarm
  function automatic logic [127:0] alarm_bit(input logic [7:0] act, input logic en);
    logic [127:0] v;
    v = '0;
    if (act != 8'hff)
      v[act[6:0]] = en;
    return v;
  endfunction

  initial
  begin
    #(3000 * 100);
    bad_count++;
    $display("Error %0t: watchdog expired", $time);
    finish_test();
  end

  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk(contact_out, 3'h2, "reset contacts");
    chk(sensed, 3'h2, "reader sees reset contacts");
    rd_reg(8'h30, rv);
    chk(rv, 32'h0, "unmapped read");
    $display("reset test done");
    foreach (rows[i])
    begin
      @(posedge ref_clk);
      running       <= rows[i].run;
      temp_ready    <= rows[i].rdy;
      contact_in1   <= rows[i].i1;
      contact_in2   <= rows[i].i2;
      alarm_active  <= alarm_bit(rows[i].act, 1'b1);
      alarm_is_stop <= alarm_bit(rows[i].act, rows[i].stp);
      wr_reg(8'(4 * (i % 3)), cfg_word(rows[i]));
      repeat (5) @(posedge ref_clk);
      #1;
      chk(32'(contact_out[i % 3]), 32'(rows[i].ex), "row contact");
      chk(32'(sensed[i % 3]), 32'(rows[i].ex), "reader row contact");
    end
    $display("table test done");
    @(posedge ref_clk);
    alarm_active <= '0;
    wr_reg(cos_pkg::ADDR_CFG0, 32'h1000);
    wr_reg(cos_pkg::ADDR_MASK, 32'h1);
    wr_reg(cos_pkg::ADDR_STATUS, 32'h7);
    running <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    chk(32'(irq), 32'h1, "irq after change");
    rd_reg(cos_pkg::ADDR_STATUS, rv);
    chk(rv & 32'h1, 32'h1, "status bit 0");
    wr_reg(cos_pkg::ADDR_STATUS, 32'h1);
    repeat (2) @(posedge ref_clk);
    #1;
    chk(32'(irq), 32'h0, "irq cleared");
    wr_reg(cos_pkg::ADDR_MASK, 32'h0);
    running <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    chk(32'(irq), 32'h0, "masked irq");
    rd_reg(cos_pkg::ADDR_STATE, rv);
    chk(rv & 32'h1, 32'h0, "state contact 0");
    $display("interrupt test done");
    // unknown code with nc, remote and anti-freeze types
    wr_reg(cos_pkg::ADDR_CFG0, 32'hb100);
    wr_reg(cos_pkg::ADDR_CFG1, 32'h2000);
    wr_reg(cos_pkg::ADDR_CFG2, 32'h7000);
    remote      <= 1'b1;
    freeze_on   <= 1'b1;
    contact_in1 <= 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
    chk(contact_out, 3'h7, "unknown, remote and freeze codes");
    rd_reg(cos_pkg::ADDR_CFG2, rv);
    chk(rv, 32'h7000, "config read back");
    @(posedge ref_clk);
    #1;
    chk(rdata, 32'h0, "read data one cycle only");
    rd_reg(cos_pkg::ADDR_STATE, rv);
    chk(rv & 32'h18, 32'h08, "state register inputs");
    $display("code test done");
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk(contact_out, 3'h2, "contacts after second reset");
    $display("second reset test done");
    finish_test();
  end
endmodule // contact_output_selector_tb_top
